// [design/pwmb_top.sv]
/*
 * Issue-group write resolution: parallel predicate writes, predicated
 * general register writes and in-order multiway branch selection.
 * Assumes decode presents one group per cycle while ready_out is high,
 * with compare conditions already computed, all inputs on clk_sys_in.
 */
// Overview of operation
// - Many parallel compares may share one destination.
// - Unwritten predicates keep their previous value.
// - And/or compares write both destinations or neither.
// - Andcm form writes result and its complement.
// - Up to three branch slots per group.
// - Branches resolve in program order; first wins.
// - Commit only the general write with true predicate.
// - Bubbles follow every instruction pointer change.
`timescale 1ns/1ns
module pwmb_top
  import pwmb_pkg::*;
(
  input  wire logic                                               clk_sys_in,
  input  wire logic                                               nrst_in,
  input  wire logic                                               grp_valid_in,
  input  wire pwmb_pkg::pwmb_cmp_kind_t [pwmb_pkg::CMP_SLOTS-1:0] cmp_kind_in,
  input  wire logic [pwmb_pkg::CMP_SLOTS-1:0]                     cmp_cond_in,
  input  wire logic [pwmb_pkg::CMP_SLOTS-1:0][pwmb_pkg::PR_IDX_W-1:0] cmp_qp_in,
  input  wire logic [pwmb_pkg::CMP_SLOTS-1:0][pwmb_pkg::PR_IDX_W-1:0] cmp_dst1_in,
  input  wire logic [pwmb_pkg::CMP_SLOTS-1:0][pwmb_pkg::PR_IDX_W-1:0] cmp_dst2_in,
  input  wire logic [pwmb_pkg::GRW_SLOTS-1:0]                     grw_valid_in,
  input  wire logic [pwmb_pkg::GRW_SLOTS-1:0][pwmb_pkg::PR_IDX_W-1:0] grw_qp_in,
  input  wire logic [pwmb_pkg::GRW_SLOTS-1:0][pwmb_pkg::GR_IDX_W-1:0] grw_dst_in,
  input  wire logic [pwmb_pkg::GRW_SLOTS-1:0][pwmb_pkg::GR_DATA_W-1:0] grw_data_in,
  input  wire logic [pwmb_pkg::BR_SLOTS-1:0]                      br_valid_in,
  input  wire logic [pwmb_pkg::BR_SLOTS-1:0][pwmb_pkg::PR_IDX_W-1:0] br_qp_in,
  input  wire logic [pwmb_pkg::BR_SLOTS-1:0][pwmb_pkg::ADDR_W-1:0] br_target_in,
  input  wire logic [pwmb_pkg::GR_IDX_W-1:0]                      gr_rd_idx_in,
  output logic                                                    ready_out,
  output logic [pwmb_pkg::PR_NUM-1:0]                             pred_file_out,
  output logic [pwmb_pkg::GR_DATA_W-1:0]                          gr_rd_data_out,
  output logic                                                    redir_valid_out,
  output logic [pwmb_pkg::ADDR_W-1:0]                             redir_target_out
);
  import pwmb_pkg::*;

  typedef enum logic {PWMB_RUN = 1'b0, PWMB_BUBBLE = 1'b1} pwmb_state_t;

  logic [PR_NUM-1:0]    pr_reg, pr_next;
  logic [GR_DATA_W-1:0] gr_reg [GR_NUM], gr_next [GR_NUM];
  logic [GR_DATA_W-1:0] gr_rd_reg, gr_rd_next;
  pwmb_state_t          state_reg, state_next;
  logic [BUB_W-1:0]     bub_reg, bub_next;
  logic                 ready_reg, ready_next;
  logic                 redir_reg, redir_next;
  logic [ADDR_W-1:0]    tgt_reg, tgt_next;
  logic                 take;
  logic                 br_found;
  logic [ADDR_W-1:0]    br_tgt;

  pwmb_cmp_if #(.N(CMP_SLOTS)) cif ();

  pwmb_cmp_eval #(.N(CMP_SLOTS)) u_eval (
    .cif (cif.eval)
  );

  // A group is taken only while no fetch bubble is running.
  assign take = grp_valid_in & ready_reg;

  // Gate each compare by group acceptance and its qualifying predicate.
  always_comb begin
    for (int i = 0; i < CMP_SLOTS; i++) begin
      cif.kind[i] = (take && pwmb_pr_read(pr_reg, cmp_qp_in[i])) ? cmp_kind_in[i]
                                                                   : PWMB_CMP_NONE;
      cif.cond[i] = cmp_cond_in[i];
    end
  end

  // Predicate file next state. Several writers to one predicate are merged
  // without any conflict check; software keeps their values equal.
  always_comb begin
    pr_next = pr_reg;
    for (int i = 0; i < CMP_SLOTS; i++) begin
      if (cif.wr_en[i]) begin
        pr_next[cmp_dst1_in[i]] = cif.val1[i];
        pr_next[cmp_dst2_in[i]] = cif.val2[i];
      end
    end
    pr_next[0] = 1'b1;
  end

  // General register commit. Only slots with a true predicate write; if
  // software breaks exclusivity the highest slot wins, never a fault.
  always_comb begin
    gr_next = gr_reg;
    for (int i = 0; i < GRW_SLOTS; i++) begin
      if (take && grw_valid_in[i] && pwmb_pr_read(pr_reg, grw_qp_in[i])) begin
        gr_next[grw_dst_in[i]] = grw_data_in[i];
      end
    end
    gr_next[0] = GR_RESET_VAL;
    gr_rd_next = gr_reg[gr_rd_idx_in];
  end

  // Branch slots are scanned in program order; the first true one wins.
  always_comb begin
    br_found = 1'b0;
    br_tgt   = '0;
    for (int i = 0; i < BR_SLOTS; i++) begin
      if (!br_found && br_valid_in[i] && pwmb_pr_read(pr_reg, br_qp_in[i])) begin
        br_found = 1'b1;
        br_tgt   = br_target_in[i];
      end
    end
  end

  // Redirect and bubble control. Holding ready low costs throughput but
  // keeps decode from issuing down a path that fetch has abandoned.
  always_comb begin
    state_next = state_reg;
    bub_next   = bub_reg;
    ready_next = ready_reg;
    redir_next = 1'b0;
    tgt_next   = tgt_reg;
    unique case (state_reg)
      PWMB_RUN: begin
        if (take && br_found) begin
          redir_next = 1'b1;
          tgt_next   = br_tgt;
          state_next = PWMB_BUBBLE;
          bub_next   = BUB_W'(IP_BUBBLE_CYCLES - 1);
          ready_next = 1'b0;
        end
      end
      PWMB_BUBBLE: begin
        if (bub_reg == '0) begin
          state_next = PWMB_RUN;
          ready_next = 1'b1;
        end else begin
          bub_next = bub_reg - BUB_W'(1);
        end
      end
    endcase
  end

  // State registers.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pr_reg    <= PR_RESET_VAL;
      gr_reg    <= '{default: GR_RESET_VAL};
      gr_rd_reg <= GR_RESET_VAL;
      state_reg <= PWMB_RUN;
      bub_reg   <= '0;
      ready_reg <= 1'b1;
      redir_reg <= 1'b0;
      tgt_reg   <= '0;
    end else begin
      pr_reg    <= pr_next;
      gr_reg    <= gr_next;
      gr_rd_reg <= gr_rd_next;
      state_reg <= state_next;
      bub_reg   <= bub_next;
      ready_reg <= ready_next;
      redir_reg <= redir_next;
      tgt_reg   <= tgt_next;
    end
  end

  assign ready_out        = ready_reg;
  assign pred_file_out    = pr_reg;
  assign gr_rd_data_out   = gr_rd_reg;
  assign redir_valid_out  = redir_reg;
  assign redir_target_out = tgt_reg;

  // Helper: exactly one general write slot qualifies, it is slot 0.
  logic gr_only0;
  assign gr_only0 = take && grw_valid_in[0] && pwmb_pr_read(pr_reg, grw_qp_in[0])
                    && (grw_dst_in[0] != '0)
                    && !(grw_valid_in[1] && pwmb_pr_read(pr_reg, grw_qp_in[1]))
                    && !(grw_valid_in[2] && pwmb_pr_read(pr_reg, grw_qp_in[2]));

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  // Checks next to the logic they guard.
  AST_P0_TRUE: assert property (pred_file_out[0] == 1'b1)
    else $error("Predicate zero is not true.");
  AST_GR0_ZERO: assert property (gr_reg[0] == GR_RESET_VAL)
    else $error("General register zero is not zero.");
  AST_KEEP_UNWRITTEN: assert property ((cif.wr_en == '0) |=> $stable(pred_file_out))
    else $error("Predicates changed without any compare write.");
  AST_SHARED_DEST: assert property (
    (cif.wr_en[0] && cif.wr_en[1] && cmp_dst1_in[0] == cmp_dst1_in[1]
     && cmp_dst1_in[0] != '0 && cif.val1[0] == cif.val1[1])
    |=> pred_file_out[$past(cmp_dst1_in[0])] == $past(cif.val1[0]))
    else $error("Shared predicate destination not written.");
  for (genvar g = 0; g < CMP_SLOTS; g++) begin : g_cmp_chk
    AST_ANDOR_SAME: assert property (
      ((cif.kind[g] == PWMB_CMP_AND || cif.kind[g] == PWMB_CMP_OR) && cif.wr_en[g])
      |-> cif.val1[g] == cif.val2[g] && cif.val1[g] == cif.cond[g])
      else $error("And/or compare wrote unequal values.");
    AST_ANDCM_COMPL: assert property (
      (cif.kind[g] == PWMB_CMP_OR_ANDCM) |-> cif.wr_en[g] == cif.cond[g]
      && (!cif.wr_en[g] || (cif.val1[g] && !cif.val2[g])))
      else $error("Andcm compare did not write complement.");
  end
  AST_FIRST_BRANCH: assert property (
    (take && br_valid_in[0] && pwmb_pr_read(pr_reg, br_qp_in[0]))
    |=> redir_valid_out && redir_target_out == $past(br_target_in[0]))
    else $error("First true branch did not win.");
  AST_BUBBLE: assert property (redir_valid_out |-> !ready_out [*2] ##1 ready_out)
    else $error("Bubble length after redirect is wrong.");
  AST_GR_COMMIT: assert property (
    gr_only0 |=> gr_reg[$past(grw_dst_in[0])] == $past(grw_data_in[0]))
    else $error("Qualified general write not committed.");

  COV_THREE_BRANCH: cover property (take && br_valid_in == 3'b111 ##1 redir_valid_out);
  COV_SHARED_OR: cover property (cif.kind[0] == PWMB_CMP_OR && cif.kind[1] == PWMB_CMP_OR
                                 && cmp_dst1_in[0] == cmp_dst1_in[1]);
  COV_GR_SELECT: cover property (gr_only0 && grw_valid_in[1]);

endmodule : pwmb_top

// [inc/pwmb_pkg.sv]
/*
 * Shared constants, types and helpers for the predicated write and
 * multiway branch resolution block.
 * Assumes a single core clock; the interface, evaluator and bench also depend on this package.
 */
package pwmb_pkg;

  // Register file sizes and slot counts of one instruction group.
  localparam int PR_NUM    = 64;
  localparam int PR_IDX_W  = 6;
  localparam int GR_NUM    = 32;
  localparam int GR_IDX_W  = 5;
  localparam int GR_DATA_W = 64;
  localparam int ADDR_W    = 64;
  localparam int CMP_SLOTS = 4;
  localparam int GRW_SLOTS = 3;
  localparam int BR_SLOTS  = 3;

  // Fetch bubble inserted after every taken redirect, in clock cycles.
  localparam int IP_BUBBLE_CYCLES = 2;
  localparam int BUB_W            = 4;

  // Reset values: predicate zero reads true, all others false.
  localparam logic [PR_NUM-1:0]    PR_RESET_VAL = 64'h0000_0000_0000_0001;
  localparam logic [GR_DATA_W-1:0] GR_RESET_VAL = 64'h0000_0000_0000_0000;

  // Compare kinds as delivered by decode.
  typedef enum logic [2:0] {
    PWMB_CMP_NONE    = 3'b000,
    PWMB_CMP_PLAIN   = 3'b001,
    PWMB_CMP_AND     = 3'b010,
    PWMB_CMP_OR      = 3'b011,
    PWMB_CMP_OR_ANDCM = 3'b100
  } pwmb_cmp_kind_t;

  // Predicate read with predicate zero hard-wired true.
  function automatic logic pwmb_pr_read(input logic [PR_NUM-1:0]   file,
                                        input logic [PR_IDX_W-1:0] idx);
    logic r;
    r = (idx == '0) ? 1'b1 : file[idx];
    return r;
  endfunction : pwmb_pr_read

endpackage : pwmb_pkg

// [inc/pwmb_cmp_if.sv]
/*
 * Carrier between the resolution top and its compare evaluator.
 * Assumes pwmb_pkg is compiled first.
 */
`timescale 1ns/1ns
interface pwmb_cmp_if #(parameter int N = 4);
  pwmb_pkg::pwmb_cmp_kind_t [N-1:0] kind;
  logic [N-1:0] cond;
  logic [N-1:0] wr_en;
  logic [N-1:0] val1;
  logic [N-1:0] val2;
  modport issue (output kind, output cond, input wr_en, input val1, input val2);
  modport eval  (input kind, input cond, output wr_en, output val1, output val2);
endinterface : pwmb_cmp_if

// [design/pwmb_cmp_eval.sv]
/*
 * Compare evaluator: turns each compare slot's kind and condition into a
 * write enable and the two destination values.
 * Assumes the caller already forced the kind to none for untaken groups
 * and for slots whose qualifying predicate is false.
 */
`timescale 1ns/1ns
module pwmb_cmp_eval #(
  parameter int N = 4
) (
  pwmb_cmp_if.eval cif
);
  import pwmb_pkg::*;

  // Per-slot decode; purely combinational.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      cif.wr_en[i] = 1'b0;
      cif.val1[i]  = 1'b0;
      cif.val2[i]  = 1'b0;
      unique case (cif.kind[i])
        PWMB_CMP_NONE: begin
          cif.wr_en[i] = 1'b0;
        end
        PWMB_CMP_PLAIN: begin
          cif.wr_en[i] = 1'b1;            // An ordinary compare always writes.
          cif.val1[i]  = cif.cond[i];
          cif.val2[i]  = ~cif.cond[i];
        end
        PWMB_CMP_AND: begin
          cif.wr_en[i] = ~cif.cond[i];    // Both cleared or none.
          cif.val1[i]  = 1'b0;
          cif.val2[i]  = 1'b0;
        end
        PWMB_CMP_OR: begin
          cif.wr_en[i] = cif.cond[i];     // Both set or none.
          cif.val1[i]  = 1'b1;
          cif.val2[i]  = 1'b1;
        end
        PWMB_CMP_OR_ANDCM: begin
          cif.wr_en[i] = cif.cond[i];     // Result and complement.
          cif.val1[i]  = 1'b1;
          cif.val2[i]  = 1'b0;
        end
        default: begin
          cif.wr_en[i] = 1'b0;            // Illegal kind codes write nothing.
        end
      endcase
    end
  end

endmodule : pwmb_cmp_eval

// [bench/pwmb_issue_model.sv]
/*
 * Issue stage model: holds one instruction group on the block's inputs.
 * Assumes the bench fills slots with the staging tasks, then calls send.
 */
`timescale 1ns/1ns
module pwmb_issue_model
  import pwmb_pkg::*;
(
  input  wire logic                                              clk_in,
  input  wire logic                                              ready_in,
  output logic                                                   grp_valid_out,
  output pwmb_pkg::pwmb_cmp_kind_t [pwmb_pkg::CMP_SLOTS-1:0]     kind_out,
  output logic [pwmb_pkg::CMP_SLOTS-1:0]                         cond_out,
  output logic [pwmb_pkg::CMP_SLOTS-1:0][pwmb_pkg::PR_IDX_W-1:0] qp_out,
  output logic [pwmb_pkg::CMP_SLOTS-1:0][pwmb_pkg::PR_IDX_W-1:0] d1_out,
  output logic [pwmb_pkg::CMP_SLOTS-1:0][pwmb_pkg::PR_IDX_W-1:0] d2_out,
  output logic [pwmb_pkg::GRW_SLOTS-1:0]                         gv_out,
  output logic [pwmb_pkg::GRW_SLOTS-1:0][pwmb_pkg::PR_IDX_W-1:0] gq_out,
  output logic [pwmb_pkg::GRW_SLOTS-1:0][pwmb_pkg::GR_IDX_W-1:0] gd_out,
  output logic [pwmb_pkg::GRW_SLOTS-1:0][pwmb_pkg::GR_DATA_W-1:0] gdat_out,
  output logic [pwmb_pkg::BR_SLOTS-1:0]                          bv_out,
  output logic [pwmb_pkg::BR_SLOTS-1:0][pwmb_pkg::PR_IDX_W-1:0]  bq_out,
  output logic [pwmb_pkg::BR_SLOTS-1:0][pwmb_pkg::ADDR_W-1:0]    bt_out
);
  // Slot staging; fields only change while the group is not offered.
  task automatic cmp(input int i, input pwmb_cmp_kind_t k, input logic c,
                     input logic [PR_IDX_W-1:0] q, a, b);
    kind_out[i] = k;
    cond_out[i] = c;
    qp_out[i] = q;
    d1_out[i] = a;
    d2_out[i] = b;
  endtask : cmp

  task automatic grw(input int i, input logic [PR_IDX_W-1:0] q,
                     input logic [GR_IDX_W-1:0] d, input logic [GR_DATA_W-1:0] v);
    gv_out[i] = 1'b1;
    gq_out[i] = q;
    gd_out[i] = d;
    gdat_out[i] = v;
  endtask : grw

  task automatic br(input int i, input logic [PR_IDX_W-1:0] q,
                    input logic [ADDR_W-1:0] t);
    bv_out[i] = 1'b1;
    bq_out[i] = q;
    bt_out[i] = t;
  endtask : br

  // Empties every slot so that a new group starts from nothing. One edge
  // passes first, so the valid strobe never drops and rises in one step.
  task automatic clr();
    @(posedge clk_in);
    #1;
    foreach (kind_out[i]) kind_out[i] = PWMB_CMP_NONE;
    {cond_out, qp_out, d1_out, d2_out} = '0;
    {gv_out, gq_out, gd_out, gdat_out, bv_out, bq_out, bt_out} = '0;
  endtask : clr

  // Offers the group until an edge samples ready high, then lets go.
  // Released fields other than the kinds and slot valids flip so that stale values are never mistaken for data.
  task automatic send();
    int n;
    n = 0;
    grp_valid_out = 1'b1;
    while (ready_in !== 1'b1 && n < 50) begin
      @(negedge clk_in);
      n++;
    end
    @(posedge clk_in);
    #1;
    grp_valid_out = 1'b0;
    {cond_out, qp_out, d1_out, d2_out} = ~{cond_out, qp_out, d1_out, d2_out};
    {gq_out, gd_out, gdat_out, bq_out, bt_out} = ~{gq_out, gd_out, gdat_out, bq_out, bt_out};
  endtask : send

  // Idle group at time zero so that no input floats.
  initial begin
    grp_valid_out = 1'b0;
    foreach (kind_out[i]) kind_out[i] = PWMB_CMP_NONE;
    {cond_out, qp_out, d1_out, d2_out} = '0;
    {gv_out, gq_out, gd_out, gdat_out, bv_out, bq_out, bt_out} = '0;
  end
endmodule : pwmb_issue_model

// [bench/tb_predicated_write_and_multiway_branch.sv]
/*
 * Bench for the issue-group write resolution block.
 * Assumes pwmb_pkg, the issue model and the design are compiled first.
 */
`timescale 1ns/1ns
module tb_predicated_write_and_multiway_branch;
  import pwmb_pkg::*;
  logic                                clk_sys_in = 1'b0;
  logic                                nrst_in = 1'b0;
  logic                                grp_valid, ready, rv;
  pwmb_cmp_kind_t [CMP_SLOTS-1:0]      kind;
  logic [CMP_SLOTS-1:0]                cond;
  logic [CMP_SLOTS-1:0][PR_IDX_W-1:0]  qp, d1, d2;
  logic [GRW_SLOTS-1:0]                gv;
  logic [GRW_SLOTS-1:0][PR_IDX_W-1:0]  gq;
  logic [GRW_SLOTS-1:0][GR_IDX_W-1:0]  gd;
  logic [GRW_SLOTS-1:0][GR_DATA_W-1:0] gdat;
  logic [BR_SLOTS-1:0]                 bv;
  logic [BR_SLOTS-1:0][PR_IDX_W-1:0]   bq;
  logic [BR_SLOTS-1:0][ADDR_W-1:0]     bt;
  logic [GR_IDX_W-1:0]                 rd_idx = '0;
  logic [PR_NUM-1:0]                   pf;
  logic [GR_DATA_W-1:0]                rd_data;
  logic [ADDR_W-1:0]                   rt;
  int                                  num_errors = 0, tests_run = 0, cyc = 0;

  // Block under test and the issue stage that feeds it.
  pwmb_top DUT (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .grp_valid_in(grp_valid),
    .cmp_kind_in(kind), .cmp_cond_in(cond), .cmp_qp_in(qp), .cmp_dst1_in(d1),
    .cmp_dst2_in(d2), .grw_valid_in(gv), .grw_qp_in(gq), .grw_dst_in(gd),
    .grw_data_in(gdat), .br_valid_in(bv), .br_qp_in(bq), .br_target_in(bt),
    .gr_rd_idx_in(rd_idx), .ready_out(ready), .pred_file_out(pf),
    .gr_rd_data_out(rd_data), .redir_valid_out(rv), .redir_target_out(rt)
  );
  pwmb_issue_model P (
    .clk_in(clk_sys_in), .ready_in(ready), .grp_valid_out(grp_valid), .kind_out(kind),
    .cond_out(cond), .qp_out(qp), .d1_out(d1), .d2_out(d2), .gv_out(gv), .gq_out(gq),
    .gd_out(gd), .gdat_out(gdat), .bv_out(bv), .bq_out(bq), .bt_out(bt)
  );

  // Core clock at 100 ns, and a watchdog so that a hang still ends the run.
  always #50 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // One compare task for single flags, one for whole words.
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask : chk64

  // General read has one cycle of latency.
  task automatic rd(input logic [GR_IDX_W-1:0] i, input logic [63:0] e);
    rd_idx = i;
    @(posedge clk_sys_in);
    #1;
    chk64(rd_data, e);
  endtask : rd

  task automatic t_reset();
    chk1(ready, 1'b1);
    chk1(rv, 1'b0);
    chk64(pf, PR_RESET_VAL);
    rd(5'd0, 64'h0000_0000_0000_0000);
    $display("test reset done");
  endtask : t_reset

  // Four or compares share one destination pair; slots 0 and 1 write.
  task automatic t_or();
    P.clr();
    P.cmp(0, PWMB_CMP_PLAIN, 1'b0, 6'd0, 6'd5, 6'd63);
    P.cmp(1, PWMB_CMP_PLAIN, 1'b0, 6'd0, 6'd7, 6'd62);
    P.send();
    chk1(pf[5], 1'b0);
    P.clr();
    for (int i = 0; i < CMP_SLOTS; i++) P.cmp(i, PWMB_CMP_OR, (i < 2), 6'd0, 6'd5, 6'd7);
    P.send();
    chk1(pf[5], 1'b1);
    chk1(pf[7], 1'b1);
    $display("test or done");
  endtask : t_or

  // And compares, a write aimed at predicate zero, and a silent or compare.
  task automatic t_and();
    P.clr();
    P.cmp(0, PWMB_CMP_PLAIN, 1'b1, 6'd0, 6'd8, 6'd9);
    P.cmp(1, PWMB_CMP_PLAIN, 1'b1, 6'd0, 6'd10, 6'd11);
    P.send();
    chk1(pf[8], 1'b1);
    P.clr();
    P.cmp(0, PWMB_CMP_AND, 1'b1, 6'd0, 6'd8, 6'd10);
    P.cmp(1, PWMB_CMP_AND, 1'b0, 6'd0, 6'd8, 6'd10);
    P.cmp(2, PWMB_CMP_AND, 1'b0, 6'd0, 6'd0, 6'd0);
    P.cmp(3, PWMB_CMP_OR, 1'b0, 6'd0, 6'd5, 6'd7);
    P.send();
    chk1(pf[8], 1'b0);
    chk1(pf[10], 1'b0);
    chk1(pf[0], 1'b1);
    chk1(pf[5], 1'b1);
    chk1(pf[7], 1'b1);
    $display("test and done");
  endtask : t_and

  // Complement form, an idle complement compare and a falsely qualified plain one.
  task automatic t_andcm();
    P.clr();
    P.cmp(0, PWMB_CMP_PLAIN, 1'b0, 6'd0, 6'd1, 6'd2);
    P.send();
    P.clr();
    P.cmp(0, PWMB_CMP_OR_ANDCM, 1'b0, 6'd0, 6'd1, 6'd2);
    P.cmp(1, PWMB_CMP_OR_ANDCM, 1'b1, 6'd0, 6'd1, 6'd2);
    P.cmp(2, PWMB_CMP_OR_ANDCM, 1'b0, 6'd0, 6'd3, 6'd4);
    P.cmp(3, PWMB_CMP_PLAIN, 1'b1, 6'd9, 6'd12, 6'd13);
    P.send();
    chk1(pf[1], 1'b1);
    chk1(pf[2], 1'b0);
    chk1(pf[4], 1'b0);
    chk1(pf[12], 1'b0);
    $display("test andcm done");
  endtask : t_andcm

  // Three writers of one register, only the middle one qualified true.
  task automatic t_grw();
    P.clr();
    P.grw(0, 6'd2, 5'd3, 64'hFFFF_FFFF_FFFF_FFFF);
    P.grw(1, 6'd1, 5'd3, 64'h0123_4567_89AB_CDEF);
    P.grw(2, 6'd2, 5'd3, 64'h0000_0000_0000_0F0F);
    P.send();
    P.clr();
    P.grw(0, 6'd0, 5'd0, 64'h5555_5555_5555_5555);
    P.send();
    rd(5'd3, 64'h0123_4567_89AB_CDEF);
    rd(5'd0, 64'h0000_0000_0000_0000);
    // Slot 0 alone qualified; a later writer of the same register is off.
    P.clr();
    P.grw(0, 6'd1, 5'd4, 64'hAAAA_AAAA_AAAA_AAAA);
    P.grw(1, 6'd2, 5'd4, 64'h5555_5555_5555_5555);
    P.send();
    rd(5'd4, 64'hAAAA_AAAA_AAAA_AAAA);
    $display("test gr write done");
  endtask : t_grw

  // Three branch slots, a fall-through group, then one whose slot 0 wins.
  task automatic t_br();
    P.clr();
    P.br(0, 6'd2, 64'h0000_0000_0000_1000);
    P.br(1, 6'd1, 64'h0000_0000_0000_2000);
    P.br(2, 6'd0, 64'h0000_0000_0000_3000);
    P.send();
    chk1(rv, 1'b1);
    chk64(rt, 64'h0000_0000_0000_2000);
    chk1(ready, 1'b0);
    @(posedge clk_sys_in);
    #1;
    chk1(rv, 1'b0);
    chk1(ready, 1'b0);
    @(posedge clk_sys_in);
    #1;
    chk1(ready, 1'b1);
    P.clr();
    P.br(0, 6'd2, 64'h0000_0000_0000_1000);
    P.br(1, 6'd9, 64'h0000_0000_0000_3000);
    P.send();
    chk1(rv, 1'b0);
    chk64(rt, 64'h0000_0000_0000_2000);
    P.clr();
    P.br(0, 6'd0, 64'h0000_0000_0000_4000);
    P.br(1, 6'd0, 64'h0000_0000_0000_5000);
    P.send();
    chk1(rv, 1'b1);
    chk64(rt, 64'h0000_0000_0000_4000);
    $display("test branch done");
  endtask : t_br

  // Main sequence: reset for 20 cycles, then every scenario in turn.
  initial begin
    repeat (20) @(posedge clk_sys_in);
    #1;
    nrst_in = 1'b1;
    t_reset();
    t_or();
    t_and();
    t_andcm();
    t_grw();
    t_br();
    summarize();
  end
endmodule : tb_predicated_write_and_multiway_branch
